/* inc/rtc_regs.vh */
// rtc_regs.vh: word indices, field layout, limits, reset values and timing
// of the calendar clock block. assumes a 125 MHz core clock.
`ifndef RTC_REGS_VH
`define RTC_REGS_VH

// ==========================================================================
// timing
`define RTC_CLK_HZ 125000000
`define RTC_TICK_S 1
`define RTC_SYNC_STAGES 3

// ==========================================================================
// system word indices (word port address)
`define RTC_SW_NOW_WDAY 8'h31
`define RTC_SW_NOW_SEC 8'h32
`define RTC_SW_NOW_HM 8'h33
`define RTC_SW_NOW_MD 8'h34
`define RTC_SW_NOW_CY 8'h35
`define RTC_SW_STOP_SEC 8'h36
`define RTC_SW_STOP_HM 8'h37
`define RTC_SW_STOP_MD 8'h38
`define RTC_SW_STOP_CY 8'h39
`define RTC_SW_STOP_WC 8'h3A
`define RTC_SW_ADJ_CMD 8'h3B

// system bit indices (bit port address)
`define RTC_SB_WRITE_SEL 8'h32
`define RTC_SB_ADJ_EN 8'h3B

// ==========================================================================
// field order, also the adjust command bit order
`define RTC_NFIELDS 8
`define RTC_F_WDAY 0
`define RTC_F_SEC 1
`define RTC_F_MIN 2
`define RTC_F_HOUR 3
`define RTC_F_DAY 4
`define RTC_F_MON 5
`define RTC_F_YEAR 6
`define RTC_F_CENT 7

// ==========================================================================
// field limits in bcd
`define RTC_WDAY_MIN 8'h01
`define RTC_WDAY_MAX 8'h07
`define RTC_SEC_MIN 8'h00
`define RTC_SEC_MAX 8'h59
`define RTC_MIN_MIN 8'h00
`define RTC_MIN_MAX 8'h59
`define RTC_HOUR_MIN 8'h00
`define RTC_HOUR_MAX 8'h23
`define RTC_DAY_MIN 8'h01
`define RTC_DAY_31 8'h31
`define RTC_DAY_30 8'h30
`define RTC_DAY_29 8'h29
`define RTC_DAY_28 8'h28
`define RTC_MON_MIN 8'h01
`define RTC_MON_MAX 8'h12
`define RTC_MON_FEB 8'h02
`define RTC_MON_APR 8'h04
`define RTC_MON_JUN 8'h06
`define RTC_MON_SEP 8'h09
`define RTC_MON_NOV 8'h11
`define RTC_YEAR_MIN 8'h00
`define RTC_YEAR_MAX 8'h99
`define RTC_CENT_MIN 8'h00
`define RTC_CENT_MAX 8'h99
`define RTC_BCD_NINE 4'h9
`define RTC_BCD_ZERO 4'h0
`define RTC_BCD_ONE 4'h1

// ==========================================================================
// reset values and fixed bytes
`define RTC_RST_WDAY 8'h01
`define RTC_RST_DAY 8'h01
`define RTC_RST_MON 8'h01
`define RTC_RST_CENT 8'h20
`define RTC_BYTE_ZERO 8'h00
`define RTC_WORD_ZERO 16'h0000

// ==========================================================================
// stop cause codes (bcd)
`define RTC_CAUSE_NONE 8'h00
`define RTC_CAUSE_STOP 8'h01
`define RTC_CAUSE_SW 8'h02
`define RTC_CAUSE_POWER 8'h04
`define RTC_CAUSE_HW 8'h05
`define RTC_CAUSE_HALT 8'h06

`endif

/* design/rtc_bcd_step.v */
// rtc_bcd_step: one bcd field, stepped up or down by one with wrap.
// assumes the field already lies within [i_min, i_max].
`timescale 1ns/1ps
`include "rtc_regs.vh"

module rtc_bcd_step (
  // field and its range
  input wire [7:0] i_val,
  input wire [7:0] i_min,
  input wire [7:0] i_max,
  // step requests, increment wins when both are set
  input wire i_inc,
  input wire i_dec,
  // result
  output reg [7:0] o_next
);

  // ==========================================================================
  // step
  always @* begin
    o_next = i_val;
    if (i_inc) begin
      if (i_val >= i_max)
        o_next = i_min;
      else if (i_val[3:0] == `RTC_BCD_NINE)
        o_next = {i_val[7:4] + `RTC_BCD_ONE, `RTC_BCD_ZERO};
      else
        o_next = {i_val[7:4], i_val[3:0] + `RTC_BCD_ONE};
    end else if (i_dec) begin
      if (i_val <= i_min || i_val > i_max)
        o_next = i_max;
      else if (i_val[3:0] == `RTC_BCD_ZERO)
        o_next = {i_val[7:4] - `RTC_BCD_ONE, `RTC_BCD_NINE};
      else
        o_next = {i_val[7:4], i_val[3:0] - `RTC_BCD_ONE};
    end
  end

endmodule // rtc_bcd_step

/* design/rtc_pin_sync.v */
// rtc_pin_sync: three-stage synchroniser for an asynchronous pin with a
// filtered level and a one-cycle pulse on each accepted rise.
// assumes i_pin may change at any time relative to i_clk.
`timescale 1ns/1ps
`include "rtc_regs.vh"

module rtc_pin_sync (
  // clock and reset
  input wire i_clk,
  input wire i_resetn,
  // raw pin
  input wire i_pin,
  // filtered result
  output reg o_level,
  output reg o_rise
);

  reg [`RTC_SYNC_STAGES-1:0] sync_q;

  // ==========================================================================
  // shift chain; only stages two and three are compared
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync_q <= {`RTC_SYNC_STAGES{1'b0}};
      o_level <= 1'b0;
      o_rise <= 1'b0;
    end else begin
      sync_q <= {sync_q[1:0], i_pin};
      o_rise <= 1'b0;
      if (sync_q[1] == sync_q[2] && sync_q[2] != o_level) begin
        o_level <= sync_q[2];
        o_rise <= sync_q[2];
      end
    end
  end

endmodule // rtc_pin_sync

/* design/rtc_core.v */
// rtc_core: battery-backed calendar clock seen through system words and
// system bits, with the record of the last application stop.
// assumes i_resetn is the backup-domain reset: processor power-down and
// cold starts do not assert it, so the calendar keeps counting.
//
// What this block does
// [R1] every current date and time field is shown as one bcd byte
// [R2] with write select at 0, current time words read only, writes ignored
// [R3] with write select at 1, a write to a current word loads it at once
// [R4] with adjust enable at 1, the command word steps fields from current value
// [R5] command bits 0..7 increment weekday, sec, min, hour, day, month, year, century
// [R6] command bits 8..15 decrement the same fields in the same order
// [R7] no automatic summer or winter time change is made
// [R8] on an application stop the date and time are caught in the stop record
// [R9] stop word one is seconds and 00, word two hours and minutes
// [R10] stop words three to five: month/day, century/year, weekday/cause
// [R11] steps wrap fields into their ranges, weekday 1 to 7; writes are not range checked and a month step does not reclip the day
// [R12] the stop cause is kept in bcd in the low byte of word five
// [R13] cause 1 for a switch to stop, 2 after a software fault
// [R14] cause 4 for power break or reset button, 5 for hardware fault
// [R15] cause 6 for a stop after the halt instruction
// [R16] the five current words are updated continuously
// [R17] current word layout: weekday, seconds, hour/min, month/day, century/year
// [R18] counting goes on while the processor is powered down
// [R19] each command bit steps once per write, wraps, then clears
`timescale 1ns/1ps
`include "rtc_regs.vh"

module rtc_core #(
  parameter TICK_CYCLES = `RTC_CLK_HZ * `RTC_TICK_S
) (
  // clock and reset
  input wire i_clk,
  input wire i_resetn,
  // system word port
  input wire i_sw_rd,
  input wire i_sw_wr,
  input wire [7:0] i_sw_addr,
  input wire [15:0] i_sw_wdata,
  output reg [15:0] o_sw_rdata,
  output reg o_sw_rvalid,
  // system bit port
  input wire i_sb_wr,
  input wire [7:0] i_sb_addr,
  input wire i_sb_wdata,
  output reg o_time_write_select,
  output reg o_time_adjust_enable,
  // stop events from the processor, one-cycle pulses
  input wire i_stop_mode,
  input wire i_stop_sw_fault,
  input wire i_stop_hw_fault,
  input wire i_stop_halt,
  // supply break or supply reset button, asynchronous pin
  input wire i_supply_break,
  // stop event seen, pulse
  output reg o_stop_logged
);

  // ==========================================================================
  // state
  reg [63:0] field_q;
  reg [63:0] field_d;
  reg [15:0] adj_cmd_q;
  reg [31:0] tick_cnt_q;
  reg tick_q;
  reg [15:0] stop_sec_q;
  reg [15:0] stop_hm_q;
  reg [15:0] stop_md_q;
  reg [15:0] stop_cy_q;
  reg [15:0] stop_wc_q;
  reg [7:0] cause_d;
  reg [15:0] rdata_d;
  reg [7:0] dim;
  wire [63:0] fmin;
  wire [63:0] fmax;
  wire [63:0] step_next;
  wire [7:0] at_max;
  wire [7:0] tick_step;
  wire [7:0] adj_inc;
  wire [7:0] adj_dec;
  wire adj_wr;
  wire [4:0] year_mod;
  wire leap;
  wire power_rise;
  wire stop_any;
  integer i;

  // byte views of the calendar
  wire [7:0] f_wday = field_q[`RTC_F_WDAY*8 +: 8];
  wire [7:0] f_sec = field_q[`RTC_F_SEC*8 +: 8];
  wire [7:0] f_min = field_q[`RTC_F_MIN*8 +: 8];
  wire [7:0] f_hour = field_q[`RTC_F_HOUR*8 +: 8];
  wire [7:0] f_day = field_q[`RTC_F_DAY*8 +: 8];
  wire [7:0] f_mon = field_q[`RTC_F_MON*8 +: 8];
  wire [7:0] f_year = field_q[`RTC_F_YEAR*8 +: 8];
  wire [7:0] f_cent = field_q[`RTC_F_CENT*8 +: 8];

  // ==========================================================================
  // one-second tick
  // the divider runs from the backup-domain reset only, so a processor
  // restart neither stops nor re-phases the second
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tick_cnt_q <= 32'h00000000;
      tick_q <= 1'b0;
    end else if (tick_cnt_q >= TICK_CYCLES - 1) begin
      tick_cnt_q <= 32'h00000000;
      tick_q <= 1'b1; // see [R18]
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h00000001;
      tick_q <= 1'b0;
    end
  end

  // ==========================================================================
  // field limits; the day limit follows month and leap year
  // leap test uses the year within the century only (every fourth year)
  assign year_mod = {f_year[7:4], 1'b0} + {1'b0, f_year[3:0]};
  assign leap = (year_mod[1:0] == 2'b00);

  always @* begin
    case (f_mon)
      `RTC_MON_FEB: dim = leap ? `RTC_DAY_29 : `RTC_DAY_28;
      `RTC_MON_APR, `RTC_MON_JUN, `RTC_MON_SEP, `RTC_MON_NOV: dim = `RTC_DAY_30;
      default: dim = `RTC_DAY_31;
    endcase
  end

  assign fmin = {`RTC_CENT_MIN, `RTC_YEAR_MIN, `RTC_MON_MIN, `RTC_DAY_MIN,
                 `RTC_HOUR_MIN, `RTC_MIN_MIN, `RTC_SEC_MIN, `RTC_WDAY_MIN}; // see [R11]
  assign fmax = {`RTC_CENT_MAX, `RTC_YEAR_MAX, `RTC_MON_MAX, dim,
                 `RTC_HOUR_MAX, `RTC_MIN_MAX, `RTC_SEC_MAX, `RTC_WDAY_MAX}; // see [R11]

  // ==========================================================================
  // carry chain of the running clock; plain calendar, no seasonal shift
  assign tick_step[`RTC_F_SEC] = tick_q; // see [R16]
  assign tick_step[`RTC_F_MIN] = tick_step[`RTC_F_SEC] & at_max[`RTC_F_SEC];
  assign tick_step[`RTC_F_HOUR] = tick_step[`RTC_F_MIN] & at_max[`RTC_F_MIN];
  assign tick_step[`RTC_F_DAY] = tick_step[`RTC_F_HOUR] & at_max[`RTC_F_HOUR]; // see [R7]
  assign tick_step[`RTC_F_WDAY] = tick_step[`RTC_F_DAY];
  assign tick_step[`RTC_F_MON] = tick_step[`RTC_F_DAY] & at_max[`RTC_F_DAY];
  assign tick_step[`RTC_F_YEAR] = tick_step[`RTC_F_MON] & at_max[`RTC_F_MON];
  assign tick_step[`RTC_F_CENT] = tick_step[`RTC_F_YEAR] & at_max[`RTC_F_YEAR];

  // ==========================================================================
  // incremental adjust: one step per field per command write, no carry
  assign adj_wr = i_sw_wr && (i_sw_addr == `RTC_SW_ADJ_CMD) && o_time_adjust_enable; // see [R4]
  assign adj_inc = adj_wr ? i_sw_wdata[7:0] : 8'h00; // see [R5]
  assign adj_dec = adj_wr ? i_sw_wdata[15:8] : 8'h00; // see [R6]

  // ==========================================================================
  // one stepper per field; a tick and an adjust in the same cycle give one step
  genvar g;
  generate
    for (g = 0; g < `RTC_NFIELDS; g = g + 1) begin : g_field
      assign at_max[g] = (field_q[g*8 +: 8] >= fmax[g*8 +: 8]);
      rtc_bcd_step u_step (
        .i_val(field_q[g*8 +: 8]),
        .i_min(fmin[g*8 +: 8]),
        .i_max(fmax[g*8 +: 8]),
        .i_inc(tick_step[g] | adj_inc[g]), // see [R19]
        .i_dec(adj_dec[g]),
        .o_next(step_next[g*8 +: 8])
      );
    end
  endgenerate

  // ==========================================================================
  // next calendar: an immediate write beats stepping for the word it hits
  always @* begin
    field_d = step_next;
    if (i_sw_wr && o_time_write_select) begin // see [R3]
      case (i_sw_addr)
        `RTC_SW_NOW_WDAY: begin
          field_d[`RTC_F_WDAY*8 +: 8] = i_sw_wdata[7:0]; // see [R17]
        end
        `RTC_SW_NOW_SEC: begin
          field_d[`RTC_F_SEC*8 +: 8] = i_sw_wdata[15:8];
        end
        `RTC_SW_NOW_HM: begin
          field_d[`RTC_F_MIN*8 +: 8] = i_sw_wdata[7:0];
          field_d[`RTC_F_HOUR*8 +: 8] = i_sw_wdata[15:8];
        end
        `RTC_SW_NOW_MD: begin
          field_d[`RTC_F_DAY*8 +: 8] = i_sw_wdata[7:0];
          field_d[`RTC_F_MON*8 +: 8] = i_sw_wdata[15:8];
        end
        `RTC_SW_NOW_CY: begin
          field_d[`RTC_F_YEAR*8 +: 8] = i_sw_wdata[7:0];
          field_d[`RTC_F_CENT*8 +: 8] = i_sw_wdata[15:8];
        end
        default: begin
          field_d = step_next;
        end
      endcase
    end
  end

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      field_q <= {`RTC_RST_CENT, `RTC_BYTE_ZERO, `RTC_RST_MON, `RTC_RST_DAY,
                  `RTC_BYTE_ZERO, `RTC_BYTE_ZERO, `RTC_BYTE_ZERO, `RTC_RST_WDAY};
    end else begin
      for (i = 0; i < `RTC_NFIELDS; i = i + 1) begin
        field_q[i*8 +: 8] <= field_d[i*8 +: 8]; // see [R16]
      end
    end
  end

  // ==========================================================================
  // command word holds the written value for one cycle, then clears
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      adj_cmd_q <= `RTC_WORD_ZERO;
    end else if (adj_wr) begin
      adj_cmd_q <= i_sw_wdata;
    end else begin
      adj_cmd_q <= `RTC_WORD_ZERO; // see [R19]
    end
  end

  // ==========================================================================
  // system bits
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_time_write_select <= 1'b0;
      o_time_adjust_enable <= 1'b0;
    end else if (i_sb_wr) begin
      if (i_sb_addr == `RTC_SB_WRITE_SEL)
        o_time_write_select <= i_sb_wdata; // see [R2]
      if (i_sb_addr == `RTC_SB_ADJ_EN)
        o_time_adjust_enable <= i_sb_wdata;
    end
  end

  // ==========================================================================
  // stop record
  rtc_pin_sync u_supply (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_pin(i_supply_break),
    .o_level(),
    .o_rise(power_rise)
  );

  // simultaneous causes: the most severe is kept
  always @* begin
    if (power_rise)
      cause_d = `RTC_CAUSE_POWER; // see [R14]
    else if (i_stop_hw_fault)
      cause_d = `RTC_CAUSE_HW; // see [R14]
    else if (i_stop_sw_fault)
      cause_d = `RTC_CAUSE_SW; // see [R13]
    else if (i_stop_halt)
      cause_d = `RTC_CAUSE_HALT; // see [R15]
    else if (i_stop_mode)
      cause_d = `RTC_CAUSE_STOP; // see [R13]
    else
      cause_d = `RTC_CAUSE_NONE;
  end

  assign stop_any = power_rise | i_stop_hw_fault | i_stop_sw_fault | i_stop_halt | i_stop_mode;

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stop_sec_q <= `RTC_WORD_ZERO;
      stop_hm_q <= `RTC_WORD_ZERO;
      stop_md_q <= `RTC_WORD_ZERO;
      stop_cy_q <= `RTC_WORD_ZERO;
      stop_wc_q <= `RTC_WORD_ZERO;
      o_stop_logged <= 1'b0;
    end else begin
      o_stop_logged <= stop_any;
      if (stop_any) begin // see [R8]
        stop_sec_q <= {f_sec, `RTC_BYTE_ZERO}; // see [R9]
        stop_hm_q <= {f_hour, f_min}; // see [R9]
        stop_md_q <= {f_mon, f_day}; // see [R10]
        stop_cy_q <= {f_cent, f_year}; // see [R10]
        stop_wc_q <= {f_wday, cause_d}; // see [R12]
      end
    end
  end

  // ==========================================================================
  // word read port, one cycle latency; unmapped words read zero
  always @* begin
    case (i_sw_addr)
      `RTC_SW_NOW_WDAY: rdata_d = {`RTC_BYTE_ZERO, f_wday}; // see [R1]
      `RTC_SW_NOW_SEC: rdata_d = {f_sec, `RTC_BYTE_ZERO}; // see [R17]
      `RTC_SW_NOW_HM: rdata_d = {f_hour, f_min};
      `RTC_SW_NOW_MD: rdata_d = {f_mon, f_day};
      `RTC_SW_NOW_CY: rdata_d = {f_cent, f_year};
      `RTC_SW_STOP_SEC: rdata_d = stop_sec_q;
      `RTC_SW_STOP_HM: rdata_d = stop_hm_q;
      `RTC_SW_STOP_MD: rdata_d = stop_md_q;
      `RTC_SW_STOP_CY: rdata_d = stop_cy_q;
      `RTC_SW_STOP_WC: rdata_d = stop_wc_q;
      `RTC_SW_ADJ_CMD: rdata_d = adj_cmd_q;
      default: rdata_d = `RTC_WORD_ZERO;
    endcase
  end

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_sw_rdata <= `RTC_WORD_ZERO;
      o_sw_rvalid <= 1'b0;
    end else begin
      o_sw_rvalid <= i_sw_rd;
      if (i_sw_rd)
        o_sw_rdata <= rdata_d; // see [R2]
    end
  end

endmodule // rtc_core

/* tb/rtc_core_chk_sva.sv */
// rtc_core_chk_sva: concurrent checks on the ports of the calendar clock.
// assumes a single clock domain and the active-low asynchronous reset.
`timescale 1ns/1ps

module rtc_core_chk (
  // clock and reset
  input logic i_clk,
  input logic i_resetn,
  // word port
  input logic i_sw_rd,
  input logic [7:0] i_sw_addr,
  input logic [15:0] o_sw_rdata,
  input logic o_sw_rvalid,
  // bit port
  input logic i_sb_wr,
  input logic [7:0] i_sb_addr,
  input logic i_sb_wdata,
  input logic o_time_write_select,
  input logic o_time_adjust_enable,
  // stop events
  input logic i_stop_mode,
  input logic i_stop_sw_fault,
  input logic i_stop_hw_fault,
  input logic i_stop_halt,
  input logic i_supply_break,
  input logic o_stop_logged
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  // ==========================================================================
  // word port
  a_read_answer: assert property (i_sw_rd |=> o_sw_rvalid)
    else $error("read not answered");
  a_rvalid_cause: assert property (o_sw_rvalid |-> $past(i_sw_rd))
    else $error("read valid without a read");
  a_rdata_hold: assert property (!i_sw_rd |=> $stable(o_sw_rdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (
    i_sw_rd && (i_sw_addr < 8'h31 || i_sw_addr > 8'h3B) |=> o_sw_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_wday_layout: assert property (i_sw_rd && i_sw_addr == 8'h31 |=>
    o_sw_rdata[15:8] == 8'h00 && o_sw_rdata[7:0] >= 8'h01 && o_sw_rdata[7:0] <= 8'h07)
    else $error("weekday word out of shape");
  a_sec_low_zero: assert property (
    i_sw_rd && (i_sw_addr == 8'h32 || i_sw_addr == 8'h36) |=> o_sw_rdata[7:0] == 8'h00)
    else $error("seconds word low byte not zero");

  // ==========================================================================
  // system bits
  a_sel_follow: assert property (
    i_sb_wr && i_sb_addr == 8'h32 |=> o_time_write_select == $past(i_sb_wdata))
    else $error("write select not loaded");
  a_sel_hold: assert property (
    !(i_sb_wr && i_sb_addr == 8'h32) |=> $stable(o_time_write_select))
    else $error("write select moved by itself");
  a_adj_follow: assert property (
    i_sb_wr && i_sb_addr == 8'h3B |=> o_time_adjust_enable == $past(i_sb_wdata))
    else $error("adjust enable not loaded");

  // ==========================================================================
  // stop capture
  a_stop_seen: assert property (
    i_stop_mode || i_stop_sw_fault || i_stop_hw_fault || i_stop_halt |=> o_stop_logged)
    else $error("stop event not logged");
  a_supply_seen: assert property ($rose(i_supply_break) |-> ##[2:7] o_stop_logged)
    else $error("supply break not logged");
endmodule // rtc_core_chk

/* tb/tb.sv */
// tb: self-checking bench for the calendar clock, table rows then hand tests.
// assumes rtc_core with a shortened second tick and the checker bound below.
`timescale 1ns/1ps

module tb;
  localparam int TICK = 1000;
  localparam logic [1:0] BW = 2'h0, WW = 2'h1, RD = 2'h2, EV = 2'h3;
  logic i_clk, i_resetn, i_sw_rd, i_sw_wr, i_sb_wr, i_sb_wdata, i_supply_break;
  logic [7:0] i_sw_addr, i_sb_addr;
  logic [15:0] i_sw_wdata;
  logic [3:0] ev;
  wire [15:0] o_sw_rdata;
  wire o_sw_rvalid, o_time_write_select, o_time_adjust_enable, o_stop_logged;
  int n_fail = 0;
  int samples_checked = 0;
  logic [25:0] rows [0:46];

  rtc_core #(.TICK_CYCLES(TICK)) uut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_sw_rd(i_sw_rd), .i_sw_wr(i_sw_wr),
    .i_sw_addr(i_sw_addr), .i_sw_wdata(i_sw_wdata), .o_sw_rdata(o_sw_rdata),
    .o_sw_rvalid(o_sw_rvalid), .i_sb_wr(i_sb_wr), .i_sb_addr(i_sb_addr),
    .i_sb_wdata(i_sb_wdata), .o_time_write_select(o_time_write_select),
    .o_time_adjust_enable(o_time_adjust_enable), .i_stop_mode(ev[0]),
    .i_stop_sw_fault(ev[1]), .i_stop_hw_fault(ev[2]), .i_stop_halt(ev[3]),
    .i_supply_break(i_supply_break), .o_stop_logged(o_stop_logged));

  // ==========================================================================
  // helpers
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // flags are pulses, so poll them at falling edges under a short bound
  task automatic wait_flag(input bit sel, input int lim, input string what);
    int k;
    k = 0;
    while (((sel ? o_stop_logged : o_sw_rvalid) !== 1'b1) && k < lim) begin
      @(negedge i_clk);
      k++;
    end
    check(what, 16'h0001, {15'h0000, sel ? o_stop_logged : o_sw_rvalid});
  endtask

  task automatic do_row(input logic [25:0] r);
    logic [7:0] a;
    logic [15:0] d;
    a = r[23:16];
    d = r[15:0];
    case (r[25:24])
      BW: begin
        i_sb_wr = 1'b1; i_sb_addr = a; i_sb_wdata = d[0];
      end
      WW: begin
        i_sw_wr = 1'b1; i_sw_addr = a; i_sw_wdata = d;
      end
      RD: begin
        i_sw_rd = 1'b1; i_sw_addr = a;
      end
      default: ev = 4'h1 << d[1:0];
    endcase
    @(negedge i_clk);
    {i_sb_wr, i_sw_wr, i_sw_rd} = 3'h0;
    ev = 4'h0;
    if (r[25:24] == RD) begin
      wait_flag(1'b0, 3, "read valid");
      check($sformatf("word %h", a), d, o_sw_rdata);
    end else if (r[25:24] == EV) begin
      wait_flag(1'b1, 3, "stop logged");
    end
    // idle cycle, so a strobe is never lowered and raised again in one step
    @(negedge i_clk);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ==========================================================================
  // clock and watchdog
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  initial begin
    repeat (10 * TICK) @(posedge i_clk);
    n_fail++;
    stop_test();
  end

  // ==========================================================================
  // main sequence
  initial begin
    {i_resetn, i_sw_rd, i_sw_wr, i_sb_wr, i_sb_wdata, i_supply_break} = 6'h00;
    {i_sw_addr, i_sb_addr, i_sw_wdata} = 32'h0000_0000;
    ev = 4'h0;
    rows = '{
      {RD,8'h31,16'h0001}, {WW,8'h33,16'h1230}, {RD,8'h33,16'h0000},
      {BW,8'h32,16'h0001}, {WW,8'h31,16'h0005}, {WW,8'h32,16'h4500},
      {WW,8'h33,16'h1230}, {WW,8'h34,16'h0228}, {WW,8'h35,16'h2099},
      {RD,8'h31,16'h0005}, {RD,8'h32,16'h4500}, {RD,8'h33,16'h1230},
      {RD,8'h34,16'h0228}, {RD,8'h35,16'h2099}, {BW,8'h32,16'h0000},
      {WW,8'h32,16'h0100}, {WW,8'h3B,16'h0002}, {RD,8'h32,16'h4500},
      // day 28 tops a february of year 99, so it wraps to 01 with no carry
      {BW,8'h3B,16'h0001}, {WW,8'h3B,16'h00FF}, {RD,8'h31,16'h0006},
      {RD,8'h32,16'h4600}, {RD,8'h33,16'h1331}, {RD,8'h34,16'h0301},
      {RD,8'h35,16'h2100}, {RD,8'h3B,16'h0000}, {WW,8'h3B,16'hFF00},
      // day 01 of march wraps down to 31, month length is not reclipped
      {RD,8'h31,16'h0005}, {RD,8'h32,16'h4500}, {RD,8'h33,16'h1230},
      {RD,8'h34,16'h0231}, {RD,8'h35,16'h2099}, {EV,8'h00,16'h0000},
      {RD,8'h3A,16'h0501}, {EV,8'h00,16'h0001}, {RD,8'h3A,16'h0502},
      {EV,8'h00,16'h0002}, {RD,8'h3A,16'h0505}, {EV,8'h00,16'h0003},
      {RD,8'h3A,16'h0506}, {RD,8'h36,16'h4500}, {RD,8'h37,16'h1230},
      {RD,8'h38,16'h0231}, {RD,8'h39,16'h2099}, {WW,8'h3A,16'h0000},
      {RD,8'h3A,16'h0506}, {RD,8'h40,16'h0000}};
    repeat (12) @(negedge i_clk);
    i_resetn = 1'b1;
    foreach (rows[i]) do_row(rows[i]);
    // supply break goes through the pin synchroniser, so allow a longer wait
    i_supply_break = 1'b1;
    @(negedge i_clk);
    wait_flag(1'b1, 10, "supply stop logged");
    i_supply_break = 1'b0;
    do_row({RD,8'h3A,16'h0504});
    // reset in mid-run, then reset values and a carry from seconds through hours into day and weekday on the first tick
    i_resetn = 1'b0;
    repeat (3) @(negedge i_clk);
    i_resetn = 1'b1;
    check("write select", 16'h0000, {15'h0000, o_time_write_select});
    check("adjust enable", 16'h0000, {15'h0000, o_time_adjust_enable});
    do_row({RD,8'h34,16'h0101});
    do_row({RD,8'h35,16'h2000});
    do_row({RD,8'h3A,16'h0000});
    do_row({BW,8'h32,16'h0001});
    do_row({WW,8'h32,16'h5900});
    do_row({WW,8'h33,16'h2359});
    repeat (TICK) @(negedge i_clk);
    do_row({RD,8'h32,16'h0000});
    do_row({RD,8'h33,16'h0000});
    do_row({RD,8'h34,16'h0102});
    do_row({RD,8'h31,16'h0002});
    stop_test();
  end
endmodule // tb

bind rtc_core rtc_core_chk u_chk (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_sw_rd(i_sw_rd), .i_sw_addr(i_sw_addr),
  .o_sw_rdata(o_sw_rdata), .o_sw_rvalid(o_sw_rvalid), .i_sb_wr(i_sb_wr),
  .i_sb_addr(i_sb_addr), .i_sb_wdata(i_sb_wdata), .o_time_write_select(o_time_write_select),
  .o_time_adjust_enable(o_time_adjust_enable), .i_stop_mode(i_stop_mode),
  .i_stop_sw_fault(i_stop_sw_fault), .i_stop_hw_fault(i_stop_hw_fault),
  .i_stop_halt(i_stop_halt), .i_supply_break(i_supply_break), .o_stop_logged(o_stop_logged));
